/* File: src/ucp_pkg.sv */
// shared constants and types for the usb charge-port mode control block
package ucp_pkg;

    // system clock rate and timing figures
    localparam int CLK_MHZ      = 250;
    localparam int T_DISCH_US   = 10;
    localparam int T_1V2_US     = 100;
    localparam int DISCH_CYC    = T_DISCH_US * CLK_MHZ;
    localparam int HOLD_1V2_CYC = T_1V2_US * CLK_MHZ;
    localparam int CNT_W        = 20;

    // mode-select codes, bit a is the most significant
    localparam logic [2:0] SEL_DCP_LO = 3'h0;
    localparam logic [2:0] SEL_DCP_HI = 3'h1;
    localparam logic [2:0] SEL_SDP_LO = 3'h6;
    localparam logic [2:0] SEL_CDP    = 3'h7;

    // register byte addresses
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;

    // control register fields and reset value
    localparam int          CTRL_SW_EN_BIT  = 0;
    localparam int          CTRL_RESTART_BIT = 1;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;

    // status register field positions
    localparam int ST_ROLE_LSB  = 0;
    localparam int ST_DET_LSB   = 4;
    localparam int ST_DATA_BIT  = 8;
    localparam int ST_PWR_BIT   = 9;
    localparam int ST_DISCH_BIT = 10;
    localparam int ST_FAULT_BIT = 11;

    // port role decoded from the select pins
    typedef enum logic [2:0] {
        UCP_DCP_LO = 3'h0,
        UCP_DCP_HI = 3'h1,
        UCP_SDP    = 3'h3,
        UCP_CLIENT = 3'h2,
        UCP_SDP_LO = 3'h6,
        UCP_CDP    = 3'h7
    } ucp_role_t;

    // dedicated-port auto-detect states, gray along the usual path
    typedef enum logic [1:0] {
        UCP_DIV_2V7 = 2'h0,
        UCP_MID_1V2 = 2'h1,
        UCP_SHORTED = 2'h3
    } ucp_det_t;

    // drive of the data-pair conditioning network
    typedef struct packed {
        logic divider_2v7_scheme;
        logic short_pullup_1v2;
        logic short_200_ohm;
    } ucp_line_t;

    // line sense from the data-pair comparators
    typedef struct packed {
        logic compliant_attach;
        logic line_released;
        logic divider_accepted;
    } ucp_sense_t;

endpackage

/* File: src/ucp_mode_ctrl.sv */
// usb charge-port role selection, data switch gating and dedicated-port auto-detect
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////////////////
module ucp_mode_ctrl
#(
    parameter int HOLD_1V2 = ucp_pkg::HOLD_1V2_CYC
)
(
    // clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              RESET,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // mode select and enable pins
    input  wire logic              MODE_SELECT_BIT_A,
    input  wire logic              MODE_SELECT_BIT_B,
    input  wire logic              MODE_SELECT_BIT_C,
    input  wire logic              ENABLE,
    // power path monitors and data-line sense
    input  wire logic              OVERCURRENT,
    input  wire logic              OVERTEMP,
    input  wire ucp_pkg::ucp_sense_t SENSE,
    // power path and data switch controls
    output logic                   POWER_SW_ON,
    output logic                   DATA_SW_ON,
    output logic                   DISCHARGE_ON,
    output logic                   ILIM_HI_SEL,
    output logic                   FAULT_N,
    output logic                   STATUS_N,
    output ucp_pkg::ucp_line_t     LINE_DRIVE
);
    import ucp_pkg::*;

    localparam logic [CNT_W-1:0] DISCH_LOAD = CNT_W'(DISCH_CYC);
    localparam logic [CNT_W-1:0] HOLD_LOAD  = CNT_W'(HOLD_1V2);

    ucp_role_t        role_q;
    ucp_role_t        role_d;
    ucp_det_t         det_q;
    logic [CNT_W-1:0] disch_cnt_q;
    logic [CNT_W-1:0] hold_cnt_q;
    logic [31:0]      ctrl_q;
    logic             role_chg;
    logic             quiet_pair;
    logic             disch_act;
    logic             data_role;
    logic             dcp_role;
    logic             en_eff;
    logic             wr_acc;
    logic             rd_hit;
    logic             restart;

    //////////////////////////////////////////////////////////////////////////////////////
    // role decode from the select pins
    always_comb
    begin
        case ({MODE_SELECT_BIT_A, MODE_SELECT_BIT_B, MODE_SELECT_BIT_C})
            SEL_DCP_LO: role_d = UCP_DCP_LO;
            SEL_DCP_HI: role_d = UCP_DCP_HI;
            SEL_SDP_LO: role_d = UCP_SDP_LO;
            SEL_CDP:    role_d = UCP_CDP;
            default:
            begin
                if (MODE_SELECT_BIT_A)
                    role_d = UCP_CLIENT;
                else
                    role_d = UCP_SDP;
            end
        endcase
    end

    // pairs that only move the current limit skip the discharge
    assign role_chg   = (role_d != role_q);
    assign quiet_pair = ((role_q == UCP_SDP_LO) && (role_d == UCP_CDP))
                     || ((role_q == UCP_CDP) && (role_d == UCP_SDP_LO))
                     || ((role_q == UCP_DCP_LO) && (role_d == UCP_DCP_HI))
                     || ((role_q == UCP_DCP_HI) && (role_d == UCP_DCP_LO));
    assign dcp_role   = (role_q == UCP_DCP_LO) || (role_q == UCP_DCP_HI);
    assign data_role  = !dcp_role;
    assign en_eff     = ENABLE && ctrl_q[CTRL_SW_EN_BIT];
    assign disch_act  = (disch_cnt_q != '0);

    // role register follows the pins every cycle
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            role_q <= UCP_SDP;
        else
            role_q <= role_d;
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // output discharge timer, loaded on a role change
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            disch_cnt_q <= '0;
        else if (role_chg && !quiet_pair)
            disch_cnt_q <= DISCH_LOAD;
        else if (disch_act)
            disch_cnt_q <= disch_cnt_q - CNT_W'(1);
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // dedicated-port auto-detect; the hold counter only runs in the 1.2v state
    assign restart = wr_acc && (PADDR == ADDR_CTRL) && PWDATA[CTRL_RESTART_BIT];

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            det_q      <= UCP_DIV_2V7;
            hold_cnt_q <= '0;
        end
        else if (!dcp_role || restart)
        begin
            // parked in divider so the next dcp entry starts clean
            det_q      <= UCP_DIV_2V7;
            hold_cnt_q <= '0;
        end
        else
        begin
            case (det_q)
                UCP_DIV_2V7:
                begin
                    // a divider-accepting device never trips the detector
                    if (SENSE.compliant_attach && !SENSE.divider_accepted)
                    begin
                        det_q      <= UCP_MID_1V2;
                        hold_cnt_q <= HOLD_LOAD;
                    end
                end
                UCP_MID_1V2:
                begin
                    if (hold_cnt_q <= CNT_W'(1))
                    begin
                        det_q      <= UCP_SHORTED;
                        hold_cnt_q <= '0;
                    end
                    else
                        hold_cnt_q <= hold_cnt_q - CNT_W'(1);
                end
                UCP_SHORTED:
                begin
                    if (SENSE.line_released)
                        det_q <= UCP_DIV_2V7;
                end
                default:
                    det_q <= UCP_DIV_2V7;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // line network, switch and pin outputs, all registered
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            LINE_DRIVE   <= '0;
            DATA_SW_ON   <= 1'b0;
            POWER_SW_ON  <= 1'b0;
            DISCHARGE_ON <= 1'b0;
        end
        else
        begin
            LINE_DRIVE.divider_2v7_scheme <= dcp_role && (det_q == UCP_DIV_2V7);
            LINE_DRIVE.short_pullup_1v2   <= dcp_role && (det_q == UCP_MID_1V2);
            LINE_DRIVE.short_200_ohm      <= dcp_role && (det_q == UCP_SHORTED);
            // overcurrent deliberately not a term here
            DATA_SW_ON   <= en_eff && data_role && !disch_act;
            // attach does not touch power or discharge
            POWER_SW_ON  <= (role_q != UCP_CLIENT) && !OVERTEMP && !disch_act;
            DISCHARGE_ON <= disch_act;
        end
    end

    // current limit, status and fault pins
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            ILIM_HI_SEL <= 1'b0;
            STATUS_N    <= 1'b1;
            FAULT_N     <= 1'b1;
        end
        else
        begin
            ILIM_HI_SEL <= (role_q == UCP_DCP_HI) || (role_q == UCP_CDP);
            STATUS_N    <= !((role_q == UCP_DCP_HI) || (role_q == UCP_CDP));
            if (role_q == UCP_CLIENT)
                FAULT_N <= 1'b1;
            else if ((role_q == UCP_DCP_LO) || (role_q == UCP_SDP_LO))
                FAULT_N <= !OVERTEMP;
            else
                FAULT_N <= !(OVERTEMP || OVERCURRENT);
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    assign wr_acc  = PSEL && PENABLE && PWRITE;
    assign rd_hit  = (PADDR == ADDR_CTRL) || (PADDR == ADDR_STATUS);
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !rd_hit;

    // control register; restart bit is a pulse, never stored
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            ctrl_q <= CTRL_RESET;
        else if (wr_acc && (PADDR == ADDR_CTRL))
            ctrl_q <= {31'h0000_0000, PWDATA[CTRL_SW_EN_BIT]};
    end

    // read data registered in the setup cycle
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            PRDATA <= '0;
        else if (PSEL && !PENABLE && !PWRITE)
        begin
            PRDATA <= '0;
            if (PADDR == ADDR_CTRL)
                PRDATA <= ctrl_q;
            else if (PADDR == ADDR_STATUS)
            begin
                PRDATA[ST_ROLE_LSB +: 3] <= role_q;
                PRDATA[ST_DET_LSB +: 2]  <= det_q;
                PRDATA[ST_DATA_BIT]      <= DATA_SW_ON;
                PRDATA[ST_PWR_BIT]       <= POWER_SW_ON;
                PRDATA[ST_DISCH_BIT]     <= DISCHARGE_ON;
                PRDATA[ST_FAULT_BIT]     <= !FAULT_N;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    property p_quiet_pair;
        (role_q == UCP_SDP_LO) && (role_d == UCP_CDP) && !disch_act |=> !disch_act;
    endproperty
    a_quiet_pair: assert property (p_quiet_pair) else $error("discharge on 110/111 change");

    property p_fault_masked;
        (role_q == UCP_SDP_LO) && OVERCURRENT && !OVERTEMP |=> FAULT_N;
    endproperty
    a_fault_masked: assert property (p_fault_masked) else $error("fault on masked overcurrent");

    property p_data_closed;
        en_eff && data_role && !disch_act && !OVERTEMP ##1 $stable(role_q) |-> DATA_SW_ON;
    endproperty
    a_data_closed: assert property (p_data_closed) else $error("data switch not closed");

    property p_data_open;
        !ENABLE || dcp_role || disch_act |=> !DATA_SW_ON;
    endproperty
    a_data_open: assert property (p_data_open) else $error("data switch closed illegally");

    property p_disch_open;
        DISCHARGE_ON |-> !DATA_SW_ON;
    endproperty
    a_disch_open: assert property (p_disch_open) else $error("data switch during discharge");

    property p_client_off;
        (role_q == UCP_CLIENT) |=> !POWER_SW_ON;
    endproperty
    a_client_off: assert property (p_client_off) else $error("power on in client role");

    property p_hold_len;
        dcp_role && !restart && (det_q == UCP_DIV_2V7) ##1 (det_q == UCP_MID_1V2)
            |-> (det_q == UCP_MID_1V2) [*8];
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("1.2v scheme too short");

    property p_release;
        dcp_role && (det_q == UCP_SHORTED) && SENSE.line_released |=> (det_q == UCP_DIV_2V7);
    endproperty
    a_release: assert property (p_release) else $error("no return to divider");

    property p_reenter;
        !dcp_role |=> (det_q == UCP_DIV_2V7);
    endproperty
    a_reenter: assert property (p_reenter) else $error("detector not reset");

    // the software enable bit counts as part of the enable condition
    property p_data_en;
        DATA_SW_ON |-> $past(en_eff);
    endproperty
    a_data_en: assert property (p_data_en) else $error("data switch without enable");

    property p_oc_keep;
        DATA_SW_ON && OVERCURRENT && en_eff && data_role && !disch_act |=> DATA_SW_ON;
    endproperty
    a_oc_keep: assert property (p_oc_keep) else $error("current limit opened data switch");

    property p_div_drive;
        dcp_role && (det_q == UCP_DIV_2V7) |=> LINE_DRIVE.divider_2v7_scheme;
    endproperty
    a_div_drive: assert property (p_div_drive) else $error("divider scheme not driven");

    property p_short_drive;
        dcp_role && (det_q == UCP_SHORTED) |=> LINE_DRIVE.short_200_ohm;
    endproperty
    a_short_drive: assert property (p_short_drive) else $error("lines not joined");

    // an accepting device must not be pushed into the 1.2v scheme
    property p_accept_stay;
        dcp_role && !restart && (det_q == UCP_DIV_2V7) && SENSE.divider_accepted
            |=> (det_q == UCP_DIV_2V7);
    endproperty
    a_accept_stay: assert property (p_accept_stay) else $error("divider state left");

    c_full_detect: cover property ((det_q == UCP_MID_1V2) ##1 (det_q == UCP_SHORTED));
    c_accept:      cover property (SENSE.divider_accepted && LINE_DRIVE.divider_2v7_scheme);
    c_discharge:   cover property ($rose(DISCHARGE_ON));
    c_client:      cover property ((role_q == UCP_CLIENT) && DATA_SW_ON);

endmodule

/* File: sim/ucp_portable_model.sv */
// portable device model facing the charge port data pair
`timescale 1ns/100ps
module ucp_portable_model
(
    // clock
    input  wire logic               clk,
    // 0 none, 1 bc compliant, 2 divider only, 3 attached but silent
    input  wire logic [1:0]         attach_kind,
    // conditioning the port puts on the lines
    input  wire ucp_pkg::ucp_line_t line_drive,
    // what the port comparators see
    output ucp_pkg::ucp_sense_t     sense
);
    import ucp_pkg::*;

    //////////////////////////////////////////////////////////////////////
    // a compliant device probes d+ then d- only while the divider is up,
    // and goes quiet once the lines are joined
    always_ff @(posedge clk)
    begin
        // a divider-only device loads the pair too; only the accept sense tells them apart
        sense.compliant_attach <= (attach_kind == 2'h1 || attach_kind == 2'h2)
                                  && line_drive.divider_2v7_scheme;
        sense.divider_accepted <= attach_kind == 2'h2 && line_drive.divider_2v7_scheme;
        sense.line_released    <= attach_kind == 2'h0; // unplug lets go of the line
    end
endmodule

/* File: sim/usb_charge_port_mode_control_bench.sv */
// self-checking bench for the charge-port mode control block
`timescale 1ns/100ps
module usb_charge_port_mode_control_bench;
    import ucp_pkg::*;

    // short 1.2 v hold keeps the run brief
    localparam int HOLD = 16;
    logic        sys_clk     = 1'b0;
    logic        reset       = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [11:0] paddr       = 12'h000;
    logic [31:0] pwdata      = 32'h0000_0000;
    logic [2:0]  mode        = 3'h3;
    logic        enable      = 1'b1;
    logic        overcurrent = 1'b0;
    logic [1:0]  attach      = 2'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    ucp_sense_t  sense;
    ucp_line_t   line_drive;
    logic        power_sw_on;
    logic        data_sw_on;
    logic        discharge_on;
    logic        ilim_hi_sel;
    logic        fault_n;
    logic        status_n;
    logic [31:0] rd;
    logic        err;
    int          n;
    int          num_errors  = 0;
    int          compares    = 0;

    //////////////////////////////////////////////////////////////////////
    // design and far-side device
    ucp_mode_ctrl #(.HOLD_1V2(HOLD)) dut_u (
        .SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .MODE_SELECT_BIT_A(mode[2]),
        .MODE_SELECT_BIT_B(mode[1]), .MODE_SELECT_BIT_C(mode[0]), .ENABLE(enable),
        .OVERCURRENT(overcurrent), .OVERTEMP(1'b0), .SENSE(sense),
        .POWER_SW_ON(power_sw_on), .DATA_SW_ON(data_sw_on), .DISCHARGE_ON(discharge_on),
        .ILIM_HI_SEL(ilim_hi_sel), .FAULT_N(fault_n), .STATUS_N(status_n),
        .LINE_DRIVE(line_drive));
    ucp_portable_model model_u (.clk(sys_clk), .attach_kind(attach),
        .line_drive(line_drive), .sense(sense));

    // 250 mhz
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end

    //////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("num_errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // lost handshake or stuck state ends the run
    task automatic give_up;
        chk(32'h0, 32'h1);
        close_out();
    endtask

    // sample a little after the edge so its updates have landed
    task automatic settle(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge sys_clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
            give_up();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_mode(input logic [2:0] c);
        @(posedge sys_clk);
        mode <= c;
        settle(3);
    endtask

    task automatic wait_disch;
        int i;
        for (i = 0; i < 3000 && discharge_on !== 1'b0; i++)
            settle(1);
        if (i == 3000)
            give_up();
    endtask

    task automatic wait_line(input logic [2:0] e);
        for (n = 0; n < 100 && line_drive !== e; n++)
            settle(1);
        if (n == 100)
            give_up();
    endtask

    //////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, CTRL_RESET);
        apb(1'b0, 12'h008, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        settle(3);
        chk(data_sw_on, 1'b0);
        apb(1'b1, ADDR_CTRL, CTRL_RESET);
        settle(3);
        chk(data_sw_on, 1'b1);
    endtask

    task automatic t_enable_oc;
        @(posedge sys_clk);
        enable <= 1'b0;
        settle(3);
        chk(data_sw_on, 1'b0);
        @(posedge sys_clk);
        enable <= 1'b1;
        overcurrent <= 1'b1;
        settle(3);
        chk(data_sw_on, 1'b1);
        chk(fault_n, 1'b0);
        set_mode(3'h6);
        wait_disch();
        settle(2);
        chk(fault_n, 1'b1);
        @(posedge sys_clk);
        overcurrent <= 1'b0;
    endtask

    task automatic t_quiet_pair;
        @(posedge sys_clk);
        mode <= 3'h7;
        repeat (6)
        begin
            settle(1);
            chk(discharge_on, 1'b0);
            chk(data_sw_on, 1'b1);
        end
    endtask

    task automatic t_roles;
        logic [2:0] e [8] = '{3'h0, 3'h1, 3'h3, 3'h3, 3'h2, 3'h2, 3'h6, 3'h7};
        for (int c = 0; c < 8; c++)
        begin
            set_mode(c[2:0]);
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk(rd[2:0], e[c]);
            chk(ilim_hi_sel, c == 1 || c == 7);
        end
        wait_disch();
    endtask

    task automatic t_dcp;
        set_mode(3'h0);
        chk(data_sw_on, 1'b0);
        chk(line_drive, 3'h4);
        wait_disch();
        chk(data_sw_on, 1'b0);
        @(posedge sys_clk);
        attach <= 2'h1;
        wait_line(3'h2);
        chk(discharge_on, 1'b0);
        chk(power_sw_on, 1'b1);
        wait_line(3'h1);
        chk(n >= HOLD - 2 && n <= HOLD + 2, 1'b1);
        settle(20);
        chk(line_drive, 3'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[5:4], 2'h3);
        // restart pulse sends the detector back to the divider scheme
        apb(1'b1, ADDR_CTRL, 32'h3);
        settle(1);
        chk(line_drive, 3'h4);
        wait_line(3'h1);
        chk(line_drive, 3'h1);
        @(posedge sys_clk);
        attach <= 2'h0;
        wait_line(3'h4);
        chk(n < 8, 1'b1);
        @(posedge sys_clk);
        attach <= 2'h2;
        settle(40);
        chk(line_drive, 3'h4);
    endtask

    // leave the dedicated role from shorted, come back in divider
    task automatic t_client;
        @(posedge sys_clk);
        attach <= 2'h1;
        wait_line(3'h1);
        @(posedge sys_clk);
        attach <= 2'h3;
        set_mode(3'h4);
        chk(data_sw_on, 1'b0);
        wait_disch();
        chk(power_sw_on, 1'b0);
        chk(data_sw_on, 1'b1);
        set_mode(3'h1);
        chk(line_drive, 3'h4);
        chk(status_n, 1'b0);
    endtask

    //////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        settle(3);
        chk(data_sw_on, 1'b1);
        t_regs();
        t_enable_oc();
        t_quiet_pair();
        t_roles();
        t_dcp();
        t_client();
        close_out();
    end
endmodule
